// ---- core/isp_defines.vh ----
// Purpose: Constants for the I2C slave register port.
// Assumes: Included by the glitch filter and slave design files.
// Notes:   Timing counts are in cycles of the 20 MHz CLOCK.
//
// How it works
// - Slave only, receive or transmit, bit rates up to 1 MHz.
// - Never holds SCL low.
// - General call address is ignored.
// - Device ID procedure gets no answer.
// - No clock generation or arbitration logic.
// - Glitch filter on SCL and SDA when selected.
// - SDA changes only while SCL is low.
// - START and STOP detected while SCL high.
// - Repeated START restarts address reception.
// - MSB first, one acknowledge per byte.
// - Transmitter releases SDA, receiver drives ack low.
// - Master NACK ends read; device releases SDA.
// - First byte is address plus direction bit.
// - Address 01010 plus two configurable low bits.
// - Write frame: address, register, data bytes.
// - FIFO address writes keep the pointer.
// - Reads auto-increment pointer, except FIFO.
// - Idle lines released high to pull-up.
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH

`define ISP_ADDR_HI        5'h0_00A
`define ISP_ADDR_GENCALL   7'h0_000
`define ISP_ADDR_DEVID     7'h0_07C
`define ISP_FIFO_ADDR_DEF  7'h0_005
`define ISP_FILT_NS        50
`define ISP_CLK_NS         50
// Filter time in whole CLOCK cycles, rounded up: 50 ns at 50 ns per cycle.
`define ISP_FILT_CYC       2'h1
`define ISP_FILT_W         2

`endif

// ---- core/isp_glitch_filter.v ----
// Purpose: Synchronise one bus line and suppress short spikes.
// Assumes: Line is asynchronous to CLOCK.
// Notes:   Output follows input after it has stood stable; with enable low it follows at once.
`timescale 1ns/10ps
`include "isp_defines.vh"
module isp_glitch_filter (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Line
    input  wire enable,
    input  wire line_in,
    output reg  line_out
);
    reg                  sync1_q;
    reg                  sync2_q;
    reg [`ISP_FILT_W-1:0] cnt_q;
    localparam [`ISP_FILT_W-1:0] FILT_CYC = `ISP_FILT_CYC;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q  <= 1'b1;
            sync2_q  <= 1'b1;
            cnt_q    <= {`ISP_FILT_W{1'b0}};
            line_out <= 1'b1;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            if (sync2_q == line_out) begin
                cnt_q <= {`ISP_FILT_W{1'b0}};
            end else if (!enable || cnt_q >= FILT_CYC) begin
                line_out <= sync2_q;
                cnt_q    <= {`ISP_FILT_W{1'b0}};
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // isp_glitch_filter

// ---- core/isp_i2c_slave.v ----
// Purpose: I2C slave port giving a master access to registers and FIFO.
// Assumes: SCL and SDA arrive from pins; register side is on CLOCK.
// Notes:   Read data must be ready one cycle after REG_RD_STB.
`timescale 1ns/10ps
`include "isp_defines.vh"
module isp_i2c_slave (
    // Clock and reset
    input  wire       CLOCK,
    input  wire       RST_N,
    // Configuration
    input  wire       I2C_SELECT,
    input  wire [1:0] ADDR_PINS,
    input  wire [1:0] ADDR_STORED,
    input  wire       ADDR_FROM_STORED,
    input  wire [6:0] FIFO_ADDR,
    // Bus lines
    input  wire       SCL_IN,
    input  wire       SDA_IN,
    output wire       SDA_OUT,
    output wire       SDA_OE,
    // Register side
    output reg  [6:0] REG_ADDR,
    output reg  [7:0] REG_WDATA,
    output reg        REG_WR_STB,
    output reg        REG_RD_STB,
    input  wire [7:0] REG_RDATA,
    output reg        BUSY
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_AACK  = 3'h2;
    localparam [2:0] ST_WRX   = 3'h3;
    localparam [2:0] ST_WACK  = 3'h4;
    localparam [2:0] ST_RTX   = 3'h5;
    localparam [2:0] ST_RACK  = 3'h6;

    wire       scl;
    wire       sda;
    reg        scl_q;
    reg        sda_q;
    reg  [2:0] state_q;
    reg  [3:0] bitcnt_q;
    reg        rw_q;
    reg        have_reg_q;
    reg        drive_low_q;
    reg        rd_pend_q;
    wire [7:0] shreg;
    reg        sh_load;
    reg  [7:0] sh_ldata;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_c;
    wire       stop_c;
    wire [6:0] my_addr;
    wire       is_fifo;

    // Filtered lines are the only view of the bus the logic uses.
    isp_glitch_filter u_scl (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .enable   (I2C_SELECT),
        .line_in  (SCL_IN),
        .line_out (scl)
    );
    isp_glitch_filter u_sda (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .enable   (I2C_SELECT),
        .line_in  (SDA_IN),
        .line_out (sda)
    );

    isp_shift_reg u_sh (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .load      (sh_load),
        .load_data (sh_ldata),
        .shift     (scl_rise && (state_q == ST_ADDR || state_q == ST_WRX)),
        .bit_in    (sda),
        .data      (shreg)
    );

    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;
    assign start_c  = scl && scl_q && sda_q && !sda;
    assign stop_c   = scl && scl_q && !sda_q && sda;
    assign my_addr  = {`ISP_ADDR_HI,
                       ADDR_FROM_STORED ? ADDR_STORED : ADDR_PINS};
    assign is_fifo  = (REG_ADDR == FIFO_ADDR);

    // Open-drain: only ever pulls low; SCL is never driven at all.
    assign SDA_OUT = 1'b0;
    assign SDA_OE  = drive_low_q;

    always @* begin
        sh_load  = 1'b0;
        sh_ldata = REG_RDATA;
        if (rd_pend_q) begin
            sh_load = 1'b1;
        end else if (state_q == ST_RTX && scl_fall && bitcnt_q != 4'h0) begin
            sh_load  = 1'b1;
            sh_ldata = {shreg[6:0], 1'b1};
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            scl_q       <= 1'b1;
            sda_q       <= 1'b1;
            state_q     <= ST_IDLE;
            bitcnt_q    <= 4'h0;
            rw_q        <= 1'b0;
            have_reg_q  <= 1'b0;
            drive_low_q <= 1'b0;
            rd_pend_q   <= 1'b0;
            REG_ADDR    <= 7'h00;
            REG_WDATA   <= 8'h00;
            REG_WR_STB  <= 1'b0;
            REG_RD_STB  <= 1'b0;
            BUSY        <= 1'b0;
        end else begin
            scl_q      <= scl;
            sda_q      <= sda;
            REG_WR_STB <= 1'b0;
            REG_RD_STB <= 1'b0;
            rd_pend_q  <= REG_RD_STB;
            if (!I2C_SELECT) begin
                state_q     <= ST_IDLE;
                drive_low_q <= 1'b0;
                BUSY        <= 1'b0;
            end else if (start_c) begin
                // A repeated START behaves exactly as a first START.
                state_q     <= ST_ADDR;
                bitcnt_q    <= 4'h0;
                drive_low_q <= 1'b0;
                BUSY        <= 1'b1;
            end else if (stop_c) begin
                state_q     <= ST_IDLE;
                drive_low_q <= 1'b0;
                BUSY        <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        drive_low_q <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                        // Acknowledge is set up only once SCL is low.
                        if (scl_fall && bitcnt_q == 4'h8) begin
                            // General call and device ID never match.
                            if (shreg[7:1] == my_addr &&
                                shreg[7:1] != `ISP_ADDR_GENCALL &&
                                shreg[7:1] != `ISP_ADDR_DEVID) begin
                                rw_q        <= shreg[0];
                                drive_low_q <= 1'b1;
                                state_q     <= ST_AACK;
                                have_reg_q  <= 1'b0;
                                if (shreg[0]) begin
                                    REG_RD_STB <= 1'b1;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            bitcnt_q <= 4'h0;
                            if (rw_q) begin
                                state_q     <= ST_RTX;
                                drive_low_q <= !shreg[7];
                                bitcnt_q    <= 4'h1;
                            end else begin
                                state_q     <= ST_WRX;
                                drive_low_q <= 1'b0;
                            end
                        end
                    end
                    ST_WRX: begin
                        if (scl_rise) begin
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                        if (scl_fall && bitcnt_q == 4'h8) begin
                            drive_low_q <= 1'b1;
                            state_q     <= ST_WACK;
                            if (!have_reg_q) begin
                                REG_ADDR   <= shreg[6:0];
                                have_reg_q <= 1'b1;
                            end else begin
                                REG_WDATA  <= shreg;
                                REG_WR_STB <= 1'b1;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            drive_low_q <= 1'b0;
                            bitcnt_q    <= 4'h0;
                            state_q     <= ST_WRX;
                        end
                        if (REG_WR_STB && !is_fifo) begin
                            REG_ADDR <= REG_ADDR + 7'h01;
                        end
                    end
                    ST_RTX: begin
                        if (scl_fall) begin
                            if (bitcnt_q == 4'h8) begin
                                drive_low_q <= 1'b0;
                                state_q     <= ST_RACK;
                                if (!is_fifo) begin
                                    REG_ADDR <= REG_ADDR + 7'h01;
                                end
                            end else begin
                                drive_low_q <= !shreg[6];
                                bitcnt_q    <= bitcnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda) begin
                                state_q <= ST_IDLE;
                            end else begin
                                REG_RD_STB <= 1'b1;
                            end
                        end
                        if (scl_fall && state_q == ST_RACK) begin
                            state_q     <= ST_RTX;
                            drive_low_q <= !shreg[7];
                            bitcnt_q    <= 4'h1;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
    // slave only; no clock generator or arbitration exists here.
endmodule // isp_i2c_slave

// ---- core/isp_shift_reg.v ----
// Purpose: Eight-bit shift register for bus bytes, MSB first.
// Assumes: Shift and load strobes are one-cycle pulses.
// Notes:   Load has priority over shift.
`timescale 1ns/10ps
module isp_shift_reg (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Control
    input  wire       load,
    input  wire [7:0] load_data,
    input  wire       shift,
    input  wire       bit_in,
    // Data
    output reg  [7:0] data
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data <= 8'h00;
        end else if (load) begin
            data <= load_data;
        end else if (shift) begin
            data <= {data[6:0], bit_in};
        end
    end
endmodule // isp_shift_reg

// ---- test/isp_host_model.sv ----
// Purpose: Host master model driving SCL and the low side of SDA.
// Assumes: SDA is a wired-and line with a pull-up in the bench.
// Notes:   One bit takes 1000 ns, the fastest rate the slave accepts.
`timescale 1ns/10ps
module isp_host_model (
    // Bus lines
    output logic      SCL,
    output logic      SDA_LOW,
    input  wire logic SDA
);
    // Only plain speed framing is sent, never a high-speed code.
    initial begin
        SCL = 1'b1;
        SDA_LOW = 1'b0;
    end
    task automatic put_bit(input logic b);
        #400 SDA_LOW = ~b;
        #200 SCL = 1'b1;
        #400 SCL = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        #400 SDA_LOW = 1'b0;
        #200 SCL = 1'b1;
        #390 b = SDA;
        #10 SCL = 1'b0;
    endtask
    task automatic start;
        #400 SDA_LOW = 1'b0;
        #200 SCL = 1'b1;
        #400 SDA_LOW = 1'b1;
        #400 SCL = 1'b0;
    endtask
    task automatic stop;
        #400 SDA_LOW = 1'b1;
        #200 SCL = 1'b1;
        #400 SDA_LOW = 1'b0;
        #600;
    endtask
    // A 20 ns dip on SDA while SCL is high must not be taken as START.
    task automatic spike;
        #400 SDA_LOW = 1'b1;
        #20 SDA_LOW = 1'b0;
        #600;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask
    task automatic recv_byte(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(~ack);
    endtask
endmodule // isp_host_model

// ---- test/isp_i2c_slave_monitor.sv ----
// Purpose: Protocol checks on the I2C slave register port.
// Assumes: Sees only the ports of isp_i2c_slave.
// Notes:   Bound to every instance of the port.
`timescale 1ns/10ps
module isp_i2c_slave_monitor (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RST_N,
    // Configuration
    input wire logic       I2C_SELECT,
    input wire logic [1:0] ADDR_PINS,
    input wire logic [1:0] ADDR_STORED,
    input wire logic       ADDR_FROM_STORED,
    input wire logic [6:0] FIFO_ADDR,
    // Bus lines
    input wire logic       SCL_IN,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    // Register side
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR_STB,
    input wire logic       REG_RD_STB,
    input wire logic [7:0] REG_RDATA,
    input wire logic       BUSY
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    chk_drive_low_only: assert property (SDA_OUT == 1'b0)
        else $error("SDA driven high");
    chk_write_pulse: assert property (REG_WR_STB |=> !REG_WR_STB)
        else $error("write strobe too long");
    chk_read_pulse: assert property (REG_RD_STB |=> !REG_RD_STB)
        else $error("read strobe too long");
    chk_strobe_in_frame: assert property (REG_WR_STB |-> BUSY)
        else $error("write outside frame");
    chk_deselect_idle: assert property
        (!I2C_SELECT [*8] |-> !SDA_OE && !BUSY)
        else $error("active while deselected");
    chk_fifo_keep: assert property
        (REG_WR_STB && REG_ADDR == FIFO_ADDR |=> (REG_ADDR == FIFO_ADDR) [*3])
        else $error("FIFO pointer moved");
    chk_write_step: assert property
        (REG_WR_STB && REG_ADDR != FIFO_ADDR
            |-> ##2 REG_ADDR == $past(REG_ADDR, 2) + 7'h01)
        else $error("pointer did not step");
    chk_stop_frees: assert property
        ($rose(SDA_IN) && SCL_IN && $past(SCL_IN, 1) && I2C_SELECT
            |-> ##[1:8] !BUSY)
        else $error("stop not seen");
    chk_drive_in_frame: assert property (SDA_OE |-> BUSY)
        else $error("SDA pulled low outside a frame");
endmodule // isp_i2c_slave_monitor

bind isp_i2c_slave isp_i2c_slave_monitor mon_u (.CLOCK, .RST_N,
    .I2C_SELECT, .ADDR_PINS, .ADDR_STORED, .ADDR_FROM_STORED, .FIFO_ADDR,
    .SCL_IN, .SDA_IN, .SDA_OUT, .SDA_OE, .REG_ADDR, .REG_WDATA,
    .REG_WR_STB, .REG_RD_STB, .REG_RDATA, .BUSY);

// ---- test/test_i2c_slave_register_port.sv ----
// Purpose: Self-checking bench for the I2C slave register port.
// Assumes: Host master model on the bus, register array behind the port.
// Notes:   Address cases run from a table; bursts and reset by hand.
`timescale 1ns/10ps
module test_i2c_slave_register_port;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        sel = 1'b1;
    logic        from_st = 1'b0;
    logic [7:0]  mem [0:127];
    logic [14:0] wq [$];
    logic        ack;
    logic [7:0]  d0, d1;
    int          miscompares = 0;
    int          samples_checked = 0;
    wire         scl, sda_low, sda_out, sda_oe, wr, rd, busy;
    wire [6:0]   addr;
    wire [7:0]   wdata;
    // The pull-up makes a released line read high.
    wire         sda = ~(sda_low | sda_oe);
    // Select and address source, address byte, expected acknowledge.
    localparam logic [10:0] ROWS [7] = '{{2'h3, 8'h52, 1'b1},
        {2'h3, 8'h54, 1'b0}, {2'h0, 8'h54, 1'b0}, {2'h2, 8'h00, 1'b0},
        {2'h2, 8'hF8, 1'b0}, {2'h2, 8'h56, 1'b0}, {2'h2, 8'h54, 1'b1}};

    isp_host_model m_u (.SCL(scl), .SDA_LOW(sda_low), .SDA(sda));
    isp_i2c_slave dut_u (.CLOCK(clock), .RST_N(rst_n), .I2C_SELECT(sel),
        .ADDR_PINS(2'h2), .ADDR_STORED(2'h1), .ADDR_FROM_STORED(from_st),
        .FIFO_ADDR(7'h05), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR_STB(wr), .REG_RD_STB(rd), .REG_RDATA(mem[addr]),
        .BUSY(busy));

    initial begin
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (wr) begin
            mem[addr] <= wdata;
            wq.push_back({addr, wdata});
        end
    end

    task automatic check(input string what, input logic [14:0] seen,
                         input logic [14:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic sb(input logic [7:0] b);
        m_u.send_byte(b, ack);
        check("ack", ack, 1'b1);
    endtask
    task automatic wr_frame(input logic [7:0] r, a, b,
                            input logic [14:0] e0, e1);
        wq.delete();
        m_u.start();
        sb(8'h54);
        sb(r);
        sb(a);
        sb(b);
        m_u.stop();
        check("first write", wq[0], e0);
        check("second write", wq[1], e1);
    endtask
    // The pointer is set by a write frame, then read after a restart.
    task automatic rd_frame(input logic [7:0] r, e0, e1);
        m_u.start();
        sb(8'h54);
        sb(r);
        m_u.start();
        sb(8'h55);
        m_u.recv_byte(d0, 1'b1);
        m_u.recv_byte(d1, 1'b0);
        m_u.stop();
        check("first read", d0, e0);
        check("second read", d1, e1);
        check("released", sda_oe, 1'b0);
        check("busy", busy, 1'b0);
    endtask

    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i) + 8'h80;
        repeat (5) @(posedge clock);
        #1 rst_n = 1'b1;
        foreach (ROWS[i]) begin
            @(posedge clock);
            #1 {sel, from_st} = ROWS[i][10:9];
            #1000 m_u.start();
            m_u.send_byte(ROWS[i][8:1], ack);
            check("address ack", ack, ROWS[i][0]);
            m_u.stop();
        end
        wr_frame(8'h10, 8'hA5, 8'h3C, {7'h10, 8'hA5}, {7'h11, 8'h3C});
        wr_frame(8'h05, 8'h11, 8'h22, {7'h05, 8'h11}, {7'h05, 8'h22});
        rd_frame(8'h10, 8'hA5, 8'h3C);
        rd_frame(8'h05, 8'h22, 8'h22);
        m_u.spike();
        check("busy after spike", busy, 1'b0);
        // A reset in mid-frame must drop the frame and the pointer.
        m_u.start();
        sb(8'h54);
        @(posedge clock);
        #1 rst_n = 1'b0;
        #100 check("busy in reset", busy, 1'b0);
        check("pointer in reset", addr, 7'h00);
        rst_n = 1'b1;
        m_u.stop();
        check("drive after reset", sda_oe, 1'b0);
        finish_test();
    end
endmodule // test_i2c_slave_register_port
